// ===== logic/opm_output_port.sv
// Twelve-bit output port with float control and special-signal routing
// What this block does
// RULE1: Twelve output bits in three groups of four, each from a writable data bit.
// RULE2: Reset sets all data bits to one and all float bits to zero.
// RULE3: Float bit one floats the terminal; zero drives the data level.
// RULE4: A set float bit floats the terminal even with special output selected.
// RULE5: With special output selected, data bit zero forces the terminal low.
// RULE6: Software keeps data one and float zero when using a special output.
// RULE7: Only groups zero and one offer special outputs; group two is plain.
// RULE8: Inverted-buzzer select routes gated inverted buzzer onto group zero bit zero.
// RULE9: Buzzer select routes gated buzzer signal onto group zero bit one.
// RULE10: Timer-clock enable puts timer clock on group zero bit two.
// RULE11: Clock-output enable puts selected oscillator clock on group zero bit three.
// RULE12: Frequency field: 11 fast, 10 slow, 01 slow/8, 00 slow/64.
// RULE13: Software starts the fast oscillator before selecting it for output.
// RULE14: Transmit-mute select routes transmit-mute control onto group one bit zero.
// RULE15: Receive-mute select routes receive-mute control onto group one bit one.
// RULE16: Hold-line select routes hold control onto group one bit two.
// RULE17: Hands-free select routes hands-free control onto group one bit three.
// RULE18: Each bit is built push-pull or open-drain; open-drain drives low only.
// RULE19: Switching a special output may glitch the terminal; not suppressed.
// RULE20: All selects, clock enable and frequency field clear on reset.
// RULE21: A selected, driven special terminal shows special signal AND data bit.
module opm_output_port
   import opm_pkg::*;
#(
   parameter logic [11:0] OPEN_DRAIN_MASK = opm_pkg::OPEN_DRAIN_DEF
)
(
   input  wire logic              I_MCLK,
   input  wire logic              I_RST,
   input  wire logic              I_CE,
   input  wire logic              i_DATA_WE,
   input  wire logic [11:0]       i_DATA_WDATA,
   input  wire logic              i_FLOAT_WE,
   input  wire logic [11:0]       i_FLOAT_WDATA,
   input  wire logic              i_SEL_WE,
   input  wire opm_pkg::opm_sel_t i_SEL_WDATA,
   input  wire logic              i_FREQ_WE,
   input  wire logic [1:0]        i_FREQ_WDATA,
   input  wire opm_pkg::opm_src_t i_SRC,
   input  wire logic              i_SLOW_OSC_CLK,
   input  wire logic              i_FAST_OSC_CLK,
   output logic [11:0]            o_PORT_OUT,
   output logic [11:0]            o_PORT_OE_N,
   output logic [11:0]            o_DATA_RD,
   output logic [11:0]            o_FLOAT_RD,
   output opm_pkg::opm_sel_t      o_SEL_RD,
   output logic [1:0]             o_FREQ_RD
);
   import opm_pkg::*;

   localparam opm_state_t STATE_RESET = '{
      data:      DATA_RESET,
      flt:       FLOAT_RESET,
      sel:       SEL_RESET,
      freq:      FREQ_RESET,
      slow_sync: 2'h0,
      fast_sync: 2'h0,
      slow_prev: 1'b0,
      div_cnt:   DIV_RESET,
      osc_clk:   1'b0,
      pin_out:   DATA_RESET,
      pin_oe_n:  OPEN_DRAIN_MASK
   };

   opm_state_t state_reg;
   opm_state_t state_next;
   logic [7:0] special;
   logic [7:0] sel_vec;
   logic [11:0] level;

   // Output enable of one pad: open-drain floats instead of driving high
   function automatic logic pad_oe_n(input logic od, input logic flt, input logic lvl);
      pad_oe_n = flt | (od & lvl); // [RULE3] [RULE4] [RULE18]
   endfunction : pad_oe_n

   // Special signal candidates, indexed like the select bits
   always_comb
   begin
      special[SEL_BUZ_INV] = ~i_SRC.buzzer & i_SRC.buzzer_enable; // [RULE8]
      special[SEL_BUZ]     = i_SRC.buzzer & i_SRC.buzzer_enable;  // [RULE9]
      special[SEL_TIMER]   = i_SRC.timer_clk;                     // [RULE10]
      special[SEL_OSC]     = state_reg.osc_clk;                   // [RULE11]
      special[SEL_TX_MUTE] = i_SRC.tx_mute_ctrl;                  // [RULE14]
      special[SEL_RX_MUTE] = i_SRC.rx_mute_ctrl;                  // [RULE15]
      special[SEL_HOLD]    = i_SRC.hold_ctrl;                     // [RULE16]
      special[SEL_HANDS]   = i_SRC.hands_free_ctrl;               // [RULE17]
      sel_vec              = state_reg.sel;
   end

   // Terminal levels; a select switch is not resynchronised, so it may glitch
   genvar g;
   generate
      for (g = 0; g < NUM_SPECIAL; g++)
      begin : g_spec
         // Data bit gates the special signal, so data zero forces low
         assign level[g] = sel_vec[g] ? (special[g] & state_reg.data[g]) // [RULE5] [RULE21] [RULE19]
                                      : state_reg.data[g];               // [RULE3]
      end
   endgenerate
   // Group two has no select path at all
   assign level[11:8] = state_reg.data[11:8]; // [RULE7]

   // Next-state logic: software writes, clock divider, registered pads
   always_comb
   begin
      state_next = state_reg;
      if (i_DATA_WE)
      begin
         state_next.data = i_DATA_WDATA; // [RULE1]
      end
      if (i_FLOAT_WE)
      begin
         state_next.flt = i_FLOAT_WDATA; // [RULE3]
      end
      if (i_SEL_WE)
      begin
         state_next.sel = i_SEL_WDATA;
      end
      if (i_FREQ_WE)
      begin
         state_next.freq = i_FREQ_WDATA;
      end
      // Oscillator clocks are foreign; only the second stage is looked at
      state_next.slow_sync = {state_reg.slow_sync[0], i_SLOW_OSC_CLK};
      state_next.fast_sync = {state_reg.fast_sync[0], i_FAST_OSC_CLK};
      state_next.slow_prev = state_reg.slow_sync[1];
      if (state_reg.slow_sync[1] & ~state_reg.slow_prev)
      begin
         state_next.div_cnt = state_reg.div_cnt + 6'h01;
      end
      // Fast clock is sampled at 100 MHz, so its copy carries jitter
      case (state_reg.freq) // [RULE12]
         FREQ_FAST:  state_next.osc_clk = state_reg.fast_sync[1];
         FREQ_SLOW:  state_next.osc_clk = state_reg.slow_sync[1];
         FREQ_DIV8:  state_next.osc_clk = state_reg.div_cnt[DIV8_TAP];
         FREQ_DIV64: state_next.osc_clk = state_reg.div_cnt[DIV64_TAP];
         default:    state_next.osc_clk = 1'b0;
      endcase
      for (int i = 0; i < NUM_BITS; i++)
      begin
         state_next.pin_out[i]  = level[i];
         state_next.pin_oe_n[i] = pad_oe_n(OPEN_DRAIN_MASK[i], state_reg.flt[i], level[i]);
      end
   end

   // State register; reset wins over clock enable, and clock enable low freezes everything else
   always_ff @(posedge I_MCLK)
   begin
      if (I_RST)
      begin
         state_reg <= STATE_RESET; // [RULE2] [RULE20]
      end
      else if (I_CE)
      begin
         state_reg <= state_next;
      end
   end

   // Pad registers and read-back copies of the software bits
   assign o_PORT_OUT  = state_reg.pin_out;
   assign o_PORT_OE_N = state_reg.pin_oe_n;
   assign o_DATA_RD   = state_reg.data;
   assign o_FLOAT_RD  = state_reg.flt;
   assign o_SEL_RD    = state_reg.sel;
   assign o_FREQ_RD   = state_reg.freq;

   // Checks against the pad, read-back and clock registers
   a_reset_pins_high: assert property (@(posedge I_MCLK) // [RULE2]
      ($past(I_RST) && !I_RST) |-> (o_PORT_OUT == DATA_RESET) && (o_FLOAT_RD == FLOAT_RESET)
                       && (o_DATA_RD == DATA_RESET))
      else $error("Reset did not leave all terminals high");

   a_reset_selects_clear: assert property (@(posedge I_MCLK) // [RULE20]
      ($past(I_RST) && !I_RST) |-> (o_SEL_RD == SEL_RESET) && (o_FREQ_RD == FREQ_RESET))
      else $error("Reset did not clear selects and frequency");

   a_data_write_taken: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE1]
      (i_DATA_WE && I_CE) |=> (o_DATA_RD == $past(i_DATA_WDATA)))
      else $error("Data write not stored");

   a_float_wins: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE4]
      (I_CE && !$past(I_RST)) |=> ((o_PORT_OE_N & $past(o_FLOAT_RD)) == $past(o_FLOAT_RD)))
      else $error("Floated terminal is driven");

   a_zero_forces_low: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE5]
      (I_CE && !$past(I_RST)) |=> ((o_PORT_OUT & ~$past(o_DATA_RD)) == 12'h000))
      else $error("Terminal high with data bit zero");

   a_grp2_plain: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE7]
      (I_CE && !$past(I_RST)) |=> (o_PORT_OUT[11:8] == $past(o_DATA_RD[11:8])))
      else $error("Group two not a plain output");

   a_buzzer_and: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE9] [RULE21]
      (I_CE && o_SEL_RD.buzzer_sel) |=> (o_PORT_OUT[1] ==
         $past(i_SRC.buzzer & i_SRC.buzzer_enable & o_DATA_RD[1])))
      else $error("Buzzer terminal wrong");

   a_timer_clk_route: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE10]
      (I_CE && o_SEL_RD.timer_clk_en && o_DATA_RD[2]) |=> (o_PORT_OUT[2] == $past(i_SRC.timer_clk)))
      else $error("Timer clock not routed");

   a_hold_line_route: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE16]
      (I_CE && !o_SEL_RD.hold_line_sel) |=> (o_PORT_OUT[6] == $past(o_DATA_RD[6])))
      else $error("Hold terminal not plain when deselected");

   a_open_drain_low: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE18]
      ((~o_PORT_OE_N & OPEN_DRAIN_MASK & o_PORT_OUT) == 12'h000))
      else $error("Open-drain terminal drives high");

   a_osc_fast_pick: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE12]
      (I_CE && (state_reg.freq == FREQ_FAST)) |=> (state_reg.osc_clk == $past(state_reg.fast_sync[1])))
      else $error("Fast clock not selected");

   // Read-back of the other software bits follows each write one cycle later
   a_float_write_taken: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE3]
      (i_FLOAT_WE && I_CE) |=> (o_FLOAT_RD == $past(i_FLOAT_WDATA)))
      else $error("Float write not stored");

   a_sel_write_taken: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE8]
      (i_SEL_WE && I_CE) |=> (o_SEL_RD == $past(i_SEL_WDATA)))
      else $error("Select write not stored");

   a_freq_write_taken: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE12]
      (i_FREQ_WE && I_CE) |=> (o_FREQ_RD == $past(i_FREQ_WDATA)))
      else $error("Frequency write not stored");

   // Clock enable low must hold every pad and the data and select bits
   a_ce_freeze: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE1]
      !I_CE |=> (o_PORT_OUT == $past(o_PORT_OUT)) && (o_PORT_OE_N == $past(o_PORT_OE_N))
                && (o_DATA_RD == $past(o_DATA_RD)) && (o_SEL_RD == $past(o_SEL_RD)))
      else $error("State moved with clock enable low");

   // Push-pull terminals drive exactly when their float bit is clear
   a_plain_drive: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE3]
      (I_CE && !$past(I_RST)) |=> ((o_PORT_OE_N & ~OPEN_DRAIN_MASK) ==
         ($past(o_FLOAT_RD) & ~OPEN_DRAIN_MASK)))
      else $error("Push-pull terminal enable does not follow float bit");

   // Each selected terminal shows its own source gated by the data bit
   a_buz_inv_route: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE8]
      (I_CE && o_SEL_RD.buzzer_inv_sel) |=> (o_PORT_OUT[0] ==
         $past(~i_SRC.buzzer & i_SRC.buzzer_enable & o_DATA_RD[0])))
      else $error("Inverted buzzer terminal wrong");

   a_osc_clk_route: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE11]
      (I_CE && o_SEL_RD.osc_clk_en) |=> (o_PORT_OUT[3] ==
         $past(state_reg.osc_clk & o_DATA_RD[3])))
      else $error("Clock output terminal wrong");

   a_tx_mute_route: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE14]
      (I_CE && o_SEL_RD.tx_mute_sel) |=> (o_PORT_OUT[4] ==
         $past(i_SRC.tx_mute_ctrl & o_DATA_RD[4])))
      else $error("Transmit mute terminal wrong");

   a_rx_mute_route: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE15]
      (I_CE && o_SEL_RD.rx_mute_sel) |=> (o_PORT_OUT[5] ==
         $past(i_SRC.rx_mute_ctrl & o_DATA_RD[5])))
      else $error("Receive mute terminal wrong");

   a_hold_sel_route: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE16]
      (I_CE && o_SEL_RD.hold_line_sel) |=> (o_PORT_OUT[6] ==
         $past(i_SRC.hold_ctrl & o_DATA_RD[6])))
      else $error("Hold terminal wrong");

   a_hands_free_route: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE17]
      (I_CE && o_SEL_RD.hands_free_sel) |=> (o_PORT_OUT[7] ==
         $past(i_SRC.hands_free_ctrl & o_DATA_RD[7])))
      else $error("Hands-free terminal wrong");

   // With the enable clear the clock terminals fall back to plain data
   a_timer_plain_off: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE10]
      (I_CE && !o_SEL_RD.timer_clk_en) |=> (o_PORT_OUT[2] == $past(o_DATA_RD[2])))
      else $error("Timer terminal not plain when disabled");

   a_osc_plain_off: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE11]
      (I_CE && !o_SEL_RD.osc_clk_en) |=> (o_PORT_OUT[3] == $past(o_DATA_RD[3])))
      else $error("Clock terminal not plain when disabled");

   // The remaining frequency codes pick their own source
   a_osc_slow_pick: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE12]
      (I_CE && (state_reg.freq == FREQ_SLOW)) |=>
         (state_reg.osc_clk == $past(state_reg.slow_sync[1])))
      else $error("Slow clock not selected");

   a_osc_div8_pick: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE12]
      (I_CE && (state_reg.freq == FREQ_DIV8)) |=>
         (state_reg.osc_clk == $past(state_reg.div_cnt[DIV8_TAP])))
      else $error("Divide-by-eight clock not selected");

   a_osc_div64_pick: assert property (@(posedge I_MCLK) disable iff (I_RST) // [RULE12]
      (I_CE && (state_reg.freq == FREQ_DIV64)) |=>
         (state_reg.osc_clk == $past(state_reg.div_cnt[DIV64_TAP])))
      else $error("Divide-by-sixty-four clock not selected");

   c_buzzer_toggle: cover property (@(posedge I_MCLK) disable iff (I_RST)
      o_SEL_RD.buzzer_sel ##1 o_PORT_OUT[1] ##1 !o_PORT_OUT[1]);
   c_osc_div64: cover property (@(posedge I_MCLK) disable iff (I_RST)
      o_SEL_RD.osc_clk_en && (o_FREQ_RD == FREQ_DIV64) && o_PORT_OUT[3]);
   c_float_special: cover property (@(posedge I_MCLK) disable iff (I_RST)
      o_SEL_RD.tx_mute_sel && o_PORT_OE_N[4]);
   c_osc_div8: cover property (@(posedge I_MCLK) disable iff (I_RST)
      o_SEL_RD.osc_clk_en && (o_FREQ_RD == FREQ_DIV8) && o_PORT_OUT[3]);
   c_data_low_special: cover property (@(posedge I_MCLK) disable iff (I_RST)
      o_SEL_RD.buzzer_inv_sel && !o_DATA_RD[0]);
endmodule : opm_output_port

// ===== logic/opm_pkg.sv
// Package for the twelve-bit output port with special-signal selection
package opm_pkg;
   localparam int          NUM_BITS      = 12;
   localparam int          GRP_BITS      = 4;
   localparam int          NUM_SPECIAL   = 8;
   localparam logic [11:0] DATA_RESET    = 12'hfff;
   localparam logic [11:0] FLOAT_RESET   = 12'h000;
   localparam logic [11:0] OPEN_DRAIN_DEF = 12'h000;
   localparam logic [1:0]  FREQ_RESET    = 2'h0;
   // Clock-output frequency codes
   localparam logic [1:0]  FREQ_FAST     = 2'h3;
   localparam logic [1:0]  FREQ_SLOW     = 2'h2;
   localparam logic [1:0]  FREQ_DIV8     = 2'h1;
   localparam logic [1:0]  FREQ_DIV64    = 2'h0;
   // Divider tap positions on the slow-clock edge counter
   localparam int          DIV_W         = 6;
   localparam int          DIV8_TAP      = 2;
   localparam int          DIV64_TAP     = 5;
   localparam logic [5:0]  DIV_RESET     = 6'h00;
   // Special-select bit positions, equal to the terminal index they steer
   localparam int          SEL_BUZ_INV   = 0;
   localparam int          SEL_BUZ       = 1;
   localparam int          SEL_TIMER     = 2;
   localparam int          SEL_OSC       = 3;
   localparam int          SEL_TX_MUTE   = 4;
   localparam int          SEL_RX_MUTE   = 5;
   localparam int          SEL_HOLD      = 6;
   localparam int          SEL_HANDS     = 7;

   typedef struct packed {
      logic hands_free_sel;
      logic hold_line_sel;
      logic rx_mute_sel;
      logic tx_mute_sel;
      logic osc_clk_en;
      logic timer_clk_en;
      logic buzzer_sel;
      logic buzzer_inv_sel;
   } opm_sel_t;

   localparam opm_sel_t SEL_RESET = '{default: 1'b0};

   typedef struct packed {
      logic buzzer_enable;
      logic buzzer;
      logic timer_clk;
      logic tx_mute_ctrl;
      logic rx_mute_ctrl;
      logic hold_ctrl;
      logic hands_free_ctrl;
   } opm_src_t;

   typedef struct packed {
      logic [11:0] data;
      logic [11:0] flt;
      opm_sel_t    sel;
      logic [1:0]  freq;
      logic [1:0]  slow_sync;
      logic [1:0]  fast_sync;
      logic        slow_prev;
      logic [5:0]  div_cnt;
      logic        osc_clk;
      logic [11:0] pin_out;
      logic [11:0] pin_oe_n;
   } opm_state_t;
endpackage : opm_pkg

// ===== verif/opm_pad_load.sv
// External loads on the port pads: a pull-up on every terminal sets the wire level
module opm_pad_load (
   input  wire logic [11:0] i_PORT_OUT,
   input  wire logic [11:0] i_PORT_OE_N,
   output logic [11:0]      o_LEVEL
);
   timeunit 1ns;
   timeprecision 1ns;
   // A released pad rises on the pull-up instead of keeping its last level
   assign o_LEVEL = i_PORT_OE_N | i_PORT_OUT;
endmodule : opm_pad_load

// ===== verif/tb_opm_output_port.sv
// Self-checking bench for the twelve-bit output port with special outputs
module tb_opm_output_port;
   timeunit 1ns;
   timeprecision 1ns;
   import opm_pkg::*;
   logic        I_MCLK = 1'b0;
   logic        I_RST  = 1'b1;
   logic        ce     = 1'b1;
   logic [3:0]  we     = 4'h0;
   logic [11:0] wd     = 12'h000;
   opm_src_t    src    = '0;
   logic        slow   = 1'b0;
   logic        fast   = 1'b0;
   logic [11:0] pout, poe_n, drd, frd, od_oe_n, lvl, e;
   logic [7:0]  sp;
   opm_sel_t    srd;
   logic [1:0]  qrd;
   int          n_mismatch = 0;
   int          n_compared = 0;
   opm_src_t    pats [3] = '{7'h55, 7'h6a, 7'h3f};

   // Free-running 100 MHz clock
   always #5 I_MCLK = ~I_MCLK;

   opm_output_port i_dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CE(ce), .i_DATA_WE(we[0]),
      .i_DATA_WDATA(wd), .i_FLOAT_WE(we[1]), .i_FLOAT_WDATA(wd), .i_SEL_WE(we[2]),
      .i_SEL_WDATA(opm_sel_t'(wd[7:0])), .i_FREQ_WE(we[3]), .i_FREQ_WDATA(wd[1:0]),
      .i_SRC(src), .i_SLOW_OSC_CLK(slow), .i_FAST_OSC_CLK(fast), .o_PORT_OUT(pout),
      .o_PORT_OE_N(poe_n), .o_DATA_RD(drd), .o_FLOAT_RD(frd), .o_SEL_RD(srd), .o_FREQ_RD(qrd));
   // Second copy built with group two open-drain
   opm_output_port #(.OPEN_DRAIN_MASK(12'hf00)) i_dut_od (.I_MCLK(I_MCLK), .I_RST(I_RST),
      .I_CE(ce), .i_DATA_WE(we[0]), .i_DATA_WDATA(wd), .i_FLOAT_WE(we[1]), .i_FLOAT_WDATA(wd),
      .i_SEL_WE(we[2]), .i_SEL_WDATA(opm_sel_t'(wd[7:0])), .i_FREQ_WE(we[3]),
      .i_FREQ_WDATA(wd[1:0]), .i_SRC(src), .i_SLOW_OSC_CLK(slow), .i_FAST_OSC_CLK(fast),
      .o_PORT_OUT(), .o_PORT_OE_N(od_oe_n), .o_DATA_RD(), .o_FLOAT_RD(), .o_SEL_RD(),
      .o_FREQ_RD());
   opm_pad_load i_load (.i_PORT_OUT(pout), .i_PORT_OE_N(poe_n), .o_LEVEL(lvl));

   task automatic chk(input string nm, input logic [11:0] ex, input logic [11:0] got);
      n_compared++;
      if (got !== ex)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   // One write cycle, then wait until the pads show it
   task automatic wr(input logic [3:0] w, input logic [11:0] v);
      @(posedge I_MCLK);
      we <= w;
      wd <= v;
      @(posedge I_MCLK);
      we <= 4'h0;
      repeat (2) @(posedge I_MCLK);
      #1;
   endtask : wr

   // Oscillator inputs held at fixed levels; the pad lags about four cycles
   task automatic osc_lvl(input logic f, input logic s, input logic [11:0] ex);
      @(posedge I_MCLK);
      fast <= f;
      slow <= s;
      repeat (6) @(posedge I_MCLK);
      #1;
      chk("osc_pad", ex, pout);
   endtask : osc_lvl

   // Sixty-four slow-clock periods, counting changes of the clock-output pad
   task automatic tog(input logic [11:0] ex);
      int   t;
      logic b;
      t = 0;
      repeat (6) @(posedge I_MCLK);
      #1;
      b = pout[3];
      for (int i = 0; i < 520; i++)
      begin
         @(posedge I_MCLK);
         slow <= i[2] & (i < 512);
         #1;
         if (pout[3] !== b)
            t++;
         b = pout[3];
      end
      chk("osc_toggles", ex, 12'(t));
   endtask : tog

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   // Hang guard: the whole sequence needs far fewer cycles than this
   initial
   begin
      #200us;
      n_mismatch++;
      $display("timeout");
      final_report();
   end

   initial
   begin
      repeat (10) @(posedge I_MCLK);
      I_RST <= 1'b0;
      @(posedge I_MCLK);
      #1;
      chk("data_rd", DATA_RESET, drd);
      chk("float_rd", FLOAT_RESET, frd);
      chk("sel_rd", 12'(SEL_RESET), 12'(srd));
      chk("freq_rd", 12'(FREQ_RESET), 12'(qrd));
      chk("pad", 12'hfff, pout);
      chk("oe_n", 12'h000, poe_n);
      chk("od_oe_n", 12'hf00, od_oe_n);
      $display("test reset done");
      wr(4'h1, 12'h5a3);
      chk("pad", 12'h5a3, pout);
      chk("od_oe_n", 12'h500, od_oe_n);
      wr(4'h2, 12'h0f0);
      chk("level", 12'h5f3, lvl);
      @(posedge I_MCLK);
      ce <= 1'b0;
      wr(4'h1, 12'h000);
      chk("data_rd", 12'h5a3, drd);
      ce <= 1'b1;
      wr(4'h2, 12'h000);
      wr(4'h1, 12'hfff);
      $display("test plain output done");
      // Each special select alone except the clock output, under three source patterns
      for (int p = 0; p < 3; p++)
      begin
         @(posedge I_MCLK);
         src <= pats[p];
         sp = {pats[p][0], pats[p][1], pats[p][2], pats[p][3], 1'b1, pats[p][4],
               pats[p][5] & pats[p][6], ~pats[p][5] & pats[p][6]};
         for (int k = 0; k < 8; k++)
            if (k != SEL_OSC)
            begin
               wr(4'h4, 12'h001 << k);
               e = 12'hfff;
               e[k] = sp[k];
               chk("pad_special", e, pout);
            end
      end
      $display("test special select done");
      @(posedge I_MCLK);
      src <= pats[0];
      wr(4'h4, 12'h0f7);
      chk("sel_rd", 12'h0f7, 12'(srd));
      wr(4'h1, 12'h0e6);
      chk("pad_data_low", 12'h0a4, pout);
      wr(4'h2, 12'h0c0);
      chk("level_float", 12'h0e4, lvl);
      wr(4'h2, 12'h000);
      wr(4'h1, 12'hfff);
      $display("test special override done");
      wr(4'h4, 12'h008);
      osc_lvl(1'b1, 1'b0, 12'hff7);
      wr(4'h8, 12'h003);
      chk("freq_rd", 12'h003, 12'(qrd));
      osc_lvl(1'b1, 1'b0, 12'hfff);
      osc_lvl(1'b0, 1'b1, 12'hff7);
      wr(4'h8, 12'h002);
      osc_lvl(1'b0, 1'b1, 12'hfff);
      osc_lvl(1'b1, 1'b0, 12'hff7);
      wr(4'h8, 12'h001);
      tog(12'd16);
      wr(4'h8, 12'h000);
      tog(12'd2);
      wr(4'h4, 12'h000);
      osc_lvl(1'b0, 1'b0, 12'hfff);
      $display("test clock output done");
      final_report();
   end
endmodule : tb_opm_output_port
